// File: hdl/bus_control_gpio_port.v
// Eight-pin bus control general-purpose port, top level
//
// Functional notes
// - Eight-pin bidirectional port, digital only
// - Per-pin direction: 0 output, 1 input
// - Reset returns every pin to input
// - Clearing bus-disable bit hands pins to bus
// - Bus function overrides direction and latch
// - Shared enable bit gates all weak pull-ups
// - Pull-up off while pin is output
// - Reset clears the shared pull-up enable
// - Bus mode: address latch pin 0, output-enable pin 1
// - Bus mode: write low pin 2, high pin 3
// - Port exists only on larger package
// - Bus mode: addr0, chip enable, byte selects pins 4-7
// - Smaller package reads port registers as zero
//
// Pin map while the memory interface owns the port
//   pin 0  address latch enable
//   pin 1  output enable
//   pin 2  write strobe, low byte
//   pin 3  write strobe, high byte
//   pin 4  byte address bit zero
//   pin 5  chip enable
//   pin 6  lower byte select
//   pin 7  upper byte select
//
// Timing notes
//   Configuration writes land on the clock edge and reach the pads at once
//   All three read ports lag their source by one clock
//   Data and latch writes in one cycle: the latch port's data is kept
//   A pin set as output has its pull-up cut, whatever the shared enable says
//
// Reset notes
//   Direction all ones: every pin an input
//   Memory interface disabled, pull-ups off, latch cleared
//   Read ports hold zero until the first clock after release
//
// Smaller package
//   Pads neither driven nor pulled; every read port returns zero
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module bus_control_gpio_port #(
   parameter PORT_PRESENT = 1,
   parameter WIDTH        = `PORT_WIDTH
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Pin input register write and read
   input  wire             pin_input_register_wr,
   input  wire [WIDTH-1:0] pin_input_register_wdata,
   output reg  [WIDTH-1:0] pin_input_register_rdata,
   // Output latch register write and read
   input  wire             output_latch_register_wr,
   input  wire [WIDTH-1:0] output_latch_register_wdata,
   output reg  [WIDTH-1:0] output_latch_register_rdata,
   // Direction register write and read
   input  wire             direction_register_wr,
   input  wire [WIDTH-1:0] direction_register_wdata,
   output reg  [WIDTH-1:0] direction_register_rdata,
   // Memory bus control register write of the disable bit
   input  wire             memory_bus_control_register_wr,
   input  wire [7:0]       memory_bus_control_register_wdata,
   output reg              ext_bus_disable,
   // Neighbour port register write of the pull-up enable bit
   input  wire             neighbour_port_register_wr,
   input  wire [7:0]       neighbour_port_register_wdata,
   output reg              pullup_enable,
   // Strobes from the external memory interface
   input  wire             addr_latch_strobe,
   input  wire             out_enable_strobe,
   input  wire             write_low_strobe,
   input  wire             write_high_strobe,
   input  wire             byte_addr_zero,
   input  wire             chip_enable_strobe,
   input  wire             lower_byte_select,
   input  wire             upper_byte_select,
   // Pads
   input  wire [WIDTH-1:0] pad_in,
   output wire [WIDTH-1:0] pad_out,
   output wire [WIDTH-1:0] pad_oe,
   output wire [WIDTH-1:0] pad_pullup
);

   // ****************************************
   // Internal signals
   // ****************************************
   // Stored configuration
   wire [WIDTH-1:0] latch_q;
   wire [WIDTH-1:0] dir_q;
   // Latch write steering
   wire             latch_wr;
   wire [WIDTH-1:0] latch_wdata;
   // Package and bus ownership
   wire             present;
   wire             bus_mode;
   wire [WIDTH-1:0] present_mask;
   // Strobe values laid out by pin
   wire [WIDTH-1:0] bus_value;
   // Per-pin cell results before package gating
   wire [WIDTH-1:0] out_raw;
   wire [WIDTH-1:0] oe_raw;
   wire [WIDTH-1:0] pu_raw;
   // Next values of the control bits
   reg              next_ext_bus_disable;
   reg              next_pullup_enable;
   // Next values of the read-back registers
   reg  [WIDTH-1:0] next_pin_rdata;
   reg  [WIDTH-1:0] next_latch_rdata;
   reg  [WIDTH-1:0] next_dir_rdata;

   // ****************************************
   // Package presence
   // ****************************************
   // Larger package carries the port; smaller one leaves it out
   assign present      = (PORT_PRESENT != 0);
   // All ones when present, all zeros when absent
   assign present_mask = {WIDTH{present}};

   // ****************************************
   // Registers
   // ****************************************

   // Either data or latch write lands in the latch; latch port wins a tie
   assign latch_wr    = pin_input_register_wr | output_latch_register_wr;
   assign latch_wdata = output_latch_register_wr ? output_latch_register_wdata
                                                 : pin_input_register_wdata;

   gpio_reg_byte #(
      .WIDTH       (WIDTH),
      .RESET_VALUE (`LATCH_RESET)
   ) u_latch (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (latch_wr),
      .wr_data (latch_wdata),
      .q       (latch_q)
   );

   // Direction resets to all inputs
   gpio_reg_byte #(
      .WIDTH       (WIDTH),
      .RESET_VALUE (`DIR_RESET)
   ) u_dir (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wr_en   (direction_register_wr),
      .wr_data (direction_register_wdata),
      .q       (dir_q)
   );

   // Bus disable: only its own bit of the control byte is kept
   always @* begin
      next_ext_bus_disable = ext_bus_disable;
      if (memory_bus_control_register_wr) begin
         next_ext_bus_disable = memory_bus_control_register_wdata[`EXT_BUS_DIS_BIT];
      end
   end

   // Shared pull-up enable: only its own bit of the neighbour byte is kept
   always @* begin
      next_pullup_enable = pullup_enable;
      if (neighbour_port_register_wr) begin
         next_pullup_enable = neighbour_port_register_wdata[`PULLUP_EN_BIT];
      end
   end

   // Memory interface starts disabled so the port comes up as plain inputs
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_bus_disable <= `EXT_BUS_DIS_RESET;
      end else begin
         ext_bus_disable <= next_ext_bus_disable;
      end
   end

   // Pull-ups start off
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pullup_enable <= `PULLUP_EN_RESET;
      end else begin
         pullup_enable <= next_pullup_enable;
      end
   end

   // ****************************************
   // Pin muxing
   // ****************************************
   assign bus_mode = ~ext_bus_disable & present;

   // Pins 0 and 1: address latch enable and output enable
   assign bus_value[`PIN_ADDR_LATCH]     = addr_latch_strobe;
   assign bus_value[`PIN_OUT_EN]         = out_enable_strobe;
   // Pins 2 and 3: low and high byte write strobes
   assign bus_value[`PIN_WRITE_LOW]      = write_low_strobe;
   assign bus_value[`PIN_WRITE_HIGH]     = write_high_strobe;
   // Pin 4: byte address bit zero
   assign bus_value[`PIN_BYTE_ADDR_ZERO] = byte_addr_zero;
   // Pin 5: chip enable
   assign bus_value[`PIN_CHIP_EN]        = chip_enable_strobe;
   // Pins 6 and 7: lower and upper byte selects
   assign bus_value[`PIN_LOWER_BYTE]     = lower_byte_select;
   assign bus_value[`PIN_UPPER_BYTE]     = upper_byte_select;

   // One cell per pin; all digital, no analog path
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         gpio_pin_cell u_cell (
            .bus_owned     (bus_mode),
            .bus_value     (bus_value[i]),
            .dir_in        (dir_q[i]),
            .latch_value   (latch_q[i]),
            .pullup_global (pullup_enable),
            .pad_out       (out_raw[i]),
            .pad_oe        (oe_raw[i]),
            .pad_pullup    (pu_raw[i])
         );
      end
   endgenerate

   // ****************************************
   // Pad gating
   // ****************************************
   // Absent port never drives or pulls its pads
   assign pad_out    = out_raw & present_mask;
   assign pad_oe     = oe_raw  & present_mask;
   assign pad_pullup = pu_raw  & present_mask;

   // ****************************************
   // Read back
   // ****************************************
   // Pin levels, latch and direction, or zeros on the smaller package
   always @* begin
      next_pin_rdata   = {WIDTH{1'b0}};
      next_latch_rdata = {WIDTH{1'b0}};
      next_dir_rdata   = {WIDTH{1'b0}};
      if (present) begin
         next_pin_rdata   = pad_in;
         next_latch_rdata = latch_q;
         next_dir_rdata   = dir_q;
      end
   end

   // Pin level register: one clock behind the pads
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_input_register_rdata <= {WIDTH{1'b0}};
      end else begin
         pin_input_register_rdata <= next_pin_rdata;
      end
   end

   // Latch read shows latch contents, not pin levels
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         output_latch_register_rdata <= {WIDTH{1'b0}};
      end else begin
         output_latch_register_rdata <= next_latch_rdata;
      end
   end

   // Direction read back
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         direction_register_rdata <= {WIDTH{1'b0}};
      end else begin
         direction_register_rdata <= next_dir_rdata;
      end
   end

endmodule

// File: hdl/gpio_pin_cell.v
// Output mux, direction override and pull-up gating for one pin
`timescale 1ns/100ps
module gpio_pin_cell (
   // Configuration
   input  wire bus_owned,
   input  wire bus_value,
   input  wire dir_in,
   input  wire latch_value,
   input  wire pullup_global,
   // Pad controls
   output wire pad_out,
   output wire pad_oe,
   output wire pad_pullup
);

   // Bus strobe wins over latch; direction ignored while bus owns the pin
   assign pad_out    = bus_owned ? bus_value : latch_value;
   assign pad_oe     = bus_owned | ~dir_in;
   // Pull-up off whenever the pin drives
   assign pad_pullup = pullup_global & ~pad_oe;

endmodule

// File: hdl/gpio_port_defines.vh
// Constants for the bus control general-purpose port
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

// Port width
`define PORT_WIDTH          8
// Reset values
`define DIR_RESET           8'hff
`define LATCH_RESET         8'h00
`define PULLUP_EN_RESET     1'b0
`define EXT_BUS_DIS_RESET   1'b1
// Field positions in the control bytes
`define EXT_BUS_DIS_BIT     7
`define PULLUP_EN_BIT       5
// Strobe positions on the port
`define PIN_ADDR_LATCH      0
`define PIN_OUT_EN          1
`define PIN_WRITE_LOW       2
`define PIN_WRITE_HIGH      3
`define PIN_BYTE_ADDR_ZERO  4
`define PIN_CHIP_EN         5
`define PIN_LOWER_BYTE      6
`define PIN_UPPER_BYTE      7

`endif

// File: hdl/gpio_reg_byte.v
// Byte-wide register with write strobe and reset value
`timescale 1ns/100ps
module gpio_reg_byte #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Write side
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   // Stored value
   output reg  [WIDTH-1:0] q
);

   // Store on write, take reset value on reset
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_VALUE;
      end else if (wr_en) begin
         q <= wr_data;
      end
   end

endmodule

// File: tb/bus_control_gpio_port_test.sv
// Self-checking bench for the bus control general-purpose port
`timescale 1ns/100ps
module bus_control_gpio_port_test;
   typedef struct {logic [7:0] t, l, m, n, s;} row_t;
   logic       clk_sys = 0, rst_n = 0, wr_d = 0, wr_l = 0, wr_t = 0, wr_m = 0, wr_n = 0;
   logic [7:0] d_d = 0, d_l = 0, d_t = 0, d_m = 0, d_n = 0, stb = 0, oe, out, pu, mk;
   wire  [7:0] rd_p, rd_l, rd_t, pad_in, pad_out, pad_oe, pad_pu;
   wire  [7:0] s_rd_p, s_rd_l, s_rd_t, s_out, s_oe, s_pu;
   wire        ebd, pue;
   int         error_cnt = 0, comparisons = 0;
   // Direction, latch, bus control, neighbour byte, strobes
   row_t       rows[5] = '{'{8'h00, 8'ha5, 8'h80, 8'h00, 8'h00}, '{8'hff, 8'h00, 8'h80, 8'h20, 8'h00},
                           '{8'h0f, 8'h3c, 8'hff, 8'hff, 8'h00}, '{8'hff, 8'h00, 8'h7f, 8'h20, 8'ha6},
                           '{8'h00, 8'hff, 8'h00, 8'hdf, 8'h59}};
   bus_control_gpio_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .pin_input_register_wr(wr_d),
      .pin_input_register_wdata(d_d), .pin_input_register_rdata(rd_p), .output_latch_register_wr(wr_l),
      .output_latch_register_wdata(d_l), .output_latch_register_rdata(rd_l), .direction_register_wr(wr_t),
      .direction_register_wdata(d_t), .direction_register_rdata(rd_t), .memory_bus_control_register_wr(wr_m),
      .memory_bus_control_register_wdata(d_m), .ext_bus_disable(ebd), .neighbour_port_register_wr(wr_n),
      .neighbour_port_register_wdata(d_n), .pullup_enable(pue), .addr_latch_strobe(stb[0]),
      .out_enable_strobe(stb[1]), .write_low_strobe(stb[2]), .write_high_strobe(stb[3]), .byte_addr_zero(stb[4]),
      .chip_enable_strobe(stb[5]), .lower_byte_select(stb[6]), .upper_byte_select(stb[7]), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu));
   pin_partner far_u (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu), .pad_in(pad_in));
   // Smaller package sharing every input: pads stay quiet, reads stay zero
   bus_control_gpio_port #(.PORT_PRESENT(0)) small_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .pin_input_register_wr(wr_d), .pin_input_register_wdata(d_d), .pin_input_register_rdata(s_rd_p),
      .output_latch_register_wr(wr_l), .output_latch_register_wdata(d_l), .output_latch_register_rdata(s_rd_l),
      .direction_register_wr(wr_t), .direction_register_wdata(d_t), .direction_register_rdata(s_rd_t),
      .memory_bus_control_register_wr(wr_m), .memory_bus_control_register_wdata(d_m), .ext_bus_disable(),
      .neighbour_port_register_wr(wr_n), .neighbour_port_register_wdata(d_n), .pullup_enable(),
      .addr_latch_strobe(stb[0]), .out_enable_strobe(stb[1]), .write_low_strobe(stb[2]), .write_high_strobe(stb[3]),
      .byte_addr_zero(stb[4]), .chip_enable_strobe(stb[5]), .lower_byte_select(stb[6]), .upper_byte_select(stb[7]),
      .pad_in(pad_in), .pad_out(s_out), .pad_oe(s_oe), .pad_pullup(s_pu));
   initial forever #10 clk_sys = ~clk_sys;
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One-cycle write of all four configuration bytes
   task automatic setup(input logic [7:0] t, input logic [7:0] l, input logic [7:0] m, input logic [7:0] n);
      @(negedge clk_sys);
      {wr_t, wr_l, wr_m, wr_n} = 4'hf;
      {d_t, d_l, d_m, d_n} = {t, l, m, n};
      @(negedge clk_sys);
      {wr_t, wr_l, wr_m, wr_n} = 4'h0;
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      chk("oe_rst", pad_oe, 8'h00);
      chk("pu_rst", pad_pu, 8'h00);
      rst_n = 1;
      @(negedge clk_sys);
      chk("dir_rst", rd_t, 8'hff);
      chk("ctl_rst", {6'h00, ebd, pue}, 8'h02);
      foreach (rows[i]) begin
         setup(rows[i].t, rows[i].l, rows[i].m, rows[i].n);
         stb = rows[i].s;
         oe = rows[i].m[7] ? ~rows[i].t : 8'hff;
         out = rows[i].m[7] ? rows[i].l : rows[i].s;
         pu = rows[i].n[5] ? ~oe : 8'h00;
         mk = oe | 8'h0f | pu;
         #1;
         chk("oe", pad_oe, oe);
         chk("out", pad_out & oe, out & oe);
         chk("pullup", pad_pu, pu);
         chk("small_pad", s_oe | s_out | s_pu, 8'h00);
         @(negedge clk_sys);
         chk("latch_rd", rd_l, rows[i].l);
         chk("dir_rd", rd_t, rows[i].t);
         chk("pin_rd", rd_p & mk, ((oe & out) | (~oe & 8'h05) | (~oe & 8'hf0 & pu)) & mk);
         chk("small_rd", s_rd_p | s_rd_l | s_rd_t, 8'h00);
      end
      // Both latch writes together, then a data-register write alone; pull-ups on before the reset
      setup(8'hf0, 8'h00, 8'h80, 8'h20);
      @(negedge clk_sys);
      {wr_d, wr_l, d_d, d_l} = {2'b11, 8'h11, 8'h22};
      @(negedge clk_sys);
      chk("latch_win", pad_out, 8'h22);
      {wr_l, d_d} = {1'b0, 8'h33};
      @(negedge clk_sys);
      wr_d = 0;
      chk("data_wr", pad_out, 8'h33);
      // Reset in mid-run releases every pin
      rst_n = 0;
      #1;
      chk("oe_mid", pad_oe, 8'h00);
      chk("pu_mid", pad_pu, 8'h00);
      @(negedge clk_sys);
      rst_n = 1;
      @(negedge clk_sys);
      chk("dir_mid", rd_t, 8'hff);
      chk("ctl_mid", {6'h00, ebd, pue}, 8'h02);
      wrap_up;
   end
   initial begin
      #20000;
      error_cnt++;
      wrap_up;
   end
endmodule

// File: tb/gpio_port_monitor.sv
// Checker for the bus control general-purpose port
`timescale 1ns/100ps
module gpio_port_monitor #(
   parameter int PORT_PRESENT = 1
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Control bits and their writes
   input wire logic       ext_bus_disable,
   input wire logic       pullup_enable,
   input wire logic       memory_bus_control_register_wr,
   input wire logic [7:0] memory_bus_control_register_wdata,
   input wire logic       neighbour_port_register_wr,
   input wire logic [7:0] neighbour_port_register_wdata,
   // Latch write
   input wire logic       output_latch_register_wr,
   input wire logic [7:0] output_latch_register_wdata,
   // Pads and pin read
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup,
   input wire logic [7:0] pin_input_register_rdata,
   // Bus strobes
   input wire logic       addr_latch_strobe,
   input wire logic       out_enable_strobe,
   input wire logic       write_low_strobe,
   input wire logic       write_high_strobe,
   input wire logic       byte_addr_zero,
   input wire logic       chip_enable_strobe,
   input wire logic       lower_byte_select,
   input wire logic       upper_byte_select
);
   localparam bit PRESENT = (PORT_PRESENT != 0);
   wire logic [7:0] stb = {upper_byte_select, lower_byte_select, chip_enable_strobe, byte_addr_zero,
                           write_high_strobe, write_low_strobe, out_enable_strobe, addr_latch_strobe};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_bus_owns_pins: assert property (PRESENT && !ext_bus_disable |-> pad_oe == 8'hff)
      else $error("bus mode pin undriven");
   a_bus_strobe_map: assert property (PRESENT && !ext_bus_disable |-> pad_out == stb)
      else $error("bus strobe misplaced");
   a_pullup_gate: assert property (pad_pullup == ({8{pullup_enable && PRESENT}} & ~pad_oe))
      else $error("pull-up gating wrong");
   a_latch_drive: assert property (PRESENT && output_latch_register_wr && ext_bus_disable
      && !memory_bus_control_register_wr |=> pad_out == $past(output_latch_register_wdata))
      else $error("latch not driven");
   a_pad_sample: assert property ($past(rst_n)
      |-> pin_input_register_rdata == (PRESENT ? $past(pad_in) : 8'h00))
      else $error("pin read wrong");
   a_absent_quiet: assert property (PRESENT || (pad_oe == 8'h00 && pad_out == 8'h00 && pad_pullup == 8'h00))
      else $error("absent port drives pads");
   a_bus_enter: assert property (memory_bus_control_register_wr
      |=> ext_bus_disable == $past(memory_bus_control_register_wdata[7]))
      else $error("bus disable not stored");
   a_pullup_write: assert property (neighbour_port_register_wr
      |=> pullup_enable == $past(neighbour_port_register_wdata[5]))
      else $error("pull-up enable not stored");
   a_reset_state: assert property (!$past(rst_n) |-> ext_bus_disable && !pullup_enable && pad_oe == 8'h00)
      else $error("reset state wrong");
   c_bus_mode: cover property (!ext_bus_disable);
   c_pullup_on: cover property (pad_pullup != 8'h00);
   c_latch_write: cover property (output_latch_register_wr && ext_bus_disable);
endmodule
bind bus_control_gpio_port gpio_port_monitor #(.PORT_PRESENT(PORT_PRESENT)) mon_u (.*);

// File: tb/pin_partner.sv
// Far-side pin model: peripheral drivers, pull-ups and floating lines
`timescale 1ns/100ps
module pin_partner #(
   parameter logic [7:0] EXT_OE  = 8'h0f,
   parameter logic [7:0] EXT_VAL = 8'h05
) (
   input  wire logic       clk_sys,
   input  wire logic [7:0] pad_out, pad_oe, pad_pullup,
   output wire logic [7:0] pad_in
);
   logic [7:0] flt = 8'h55;
   // Undriven lines without pull-up wander every cycle
   always @(posedge clk_sys) flt <= ~flt;
   // Port drive wins, then the peripheral, then the pull-up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & EXT_OE & EXT_VAL) | (~pad_oe & ~EXT_OE & (pad_pullup | flt));
endmodule
